// ---- common/csm_defs.svh ----
// Offsets, field positions, reset values and timing counts of the clock
// source manager. Included by the package users; holds definitions only.
`ifndef CSM_DEFS_SVH
`define CSM_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CSM_OFF_MCTRL     8'h00
`define CSM_OFF_PRESC     8'h01
`define CSM_OFF_LOCK      8'h02
`define CSM_OFF_STATUS    8'h03
`define CSM_OFF_FASTCTL   8'h10
`define CSM_OFF_FTRIM     8'h11
`define CSM_OFF_TTRIM     8'h12
`define CSM_OFF_SLOWCTL   8'h18
`define CSM_OFF_XTALCTL   8'h1C
`define CSM_OFF_ERR0      8'h20
`define CSM_OFF_ERR3      8'h23

// ****************************************************************
// Field positions
// ****************************************************************
`define CSM_BIT_CLOCK_OUTPUT_ENABLE    7
`define CSM_BIT_PEN       0
`define CSM_BIT_KEEP_RUNNING_BIT  1
`define CSM_BIT_XEN       0
`define CSM_BIT_XSEL      2
`define CSM_BIT_TLOCK     7

// ****************************************************************
// Reset values and source encodings
// ****************************************************************
`define CSM_RST_MCTRL     8'h00
`define CSM_RST_PRESC     8'h11
`define CSM_SRC_FAST      2'h0
`define CSM_SRC_SLOW      2'h1
`define CSM_SRC_XTAL      2'h2
`define CSM_SRC_EXT       2'h3
`define CSM_KEY_WINDOW    3'h4

// ****************************************************************
// Timing
// ****************************************************************
`define CSM_CLK_MHZ       25
`define CSM_FAST_START_NS 3000
`define CSM_SLOW_START_NS 2000
`define CSM_GATE_EDGES    17'h00004
`define CSM_XEXT_EDGES    17'h00002
`define CSM_EXT_EDGES     17'h00002
`define CSM_CSUT0_EDGES   17'h00400
`define CSM_CSUT1_EDGES   17'h04000
`define CSM_CSUT2_EDGES   17'h08000
`define CSM_CSUT3_EDGES   17'h10000
`define CSM_KHZ_DIV       5'h1F

`endif

// ---- common/csm_pkg.sv ----
// Types shared by the clock source manager and its bench.
// Assumes csm_defs.svh is included where offsets are needed.
`default_nettype none
package csm_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } csm_bus_t;

  typedef struct packed {
    logic ext;
    logic xtal;
    logic slow;
    logic fast;
  } csm_req_t;

  typedef struct packed {
    logic [7:0] hi_hv;
    logic [7:0] hi_lv;
    logic [7:0] lo_hv;
    logic [7:0] lo_lv;
  } csm_err_t;

  typedef enum logic [1:0] {
    CSM_OFF,
    CSM_ANALOG,
    CSM_GATE,
    CSM_READY
  } csm_start_t;

endpackage
`default_nettype wire

// ---- hdl/csm_top.sv ----
// Clock source manager: oscillator requests, start-up gating, trims,
// key-protected clock registers and the peripheral clock enable.
// Assumes oscillator edges arrive as one-cycle pulses on clk_i.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "csm_defs.svh"

module csm_top
  import csm_pkg::*;
#(
  parameter int FAST_START_NS = `CSM_FAST_START_NS,
  parameter int SLOW_START_NS = `CSM_SLOW_START_NS
)(
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // Register port
  input  wire csm_pkg::csm_bus_t bus_i,
  output logic [7:0]          rdata_o,
  // Key written to the protection register
  input  wire logic           io_register_key_i,
  // Peripheral clock requests
  input  wire csm_pkg::csm_req_t req_i,
  // Oscillator edges, one-cycle pulses
  input  wire csm_pkg::csm_req_t edge_i,
  // Fuses and factory row
  input  wire logic           center_freq_fuse_i,
  input  wire logic           trim_lock_fuse_i,
  input  wire logic [5:0]     fuse_freq_trim_i,
  input  wire logic [3:0]     fuse_temp_trim_i,
  input  wire csm_pkg::csm_err_t factory_info_row_i,
  // Oscillator controls and pins
  output csm_pkg::csm_req_t   osc_on_o,
  output csm_pkg::csm_req_t   osc_ready_o,
  output logic                crystal_pin_override_o,
  output logic                crystal_ext_input_o,
  output logic                ext_pin_claim_o,
  output logic                center_20mhz_o,
  output logic [5:0]          freq_trim_field_o,
  output logic [3:0]          temp_slope_trim_field_o,
  // Clock distribution
  output logic [1:0]          main_source_o,
  output logic                per_clk_en_o,
  output logic                clock_output_enable_o,
  output logic                tick_1khz_o
);
  import csm_pkg::*;

  localparam int FAST_CYC = (FAST_START_NS * `CSM_CLK_MHZ + 999) / 1000;
  localparam int SLOW_CYC = (SLOW_START_NS * `CSM_CLK_MHZ + 999) / 1000;

  // Division ratio minus one for each divide code; reserved codes act as 2
  function automatic logic [5:0] div_last(input logic [3:0] code);
    unique case (code)
      4'h0: div_last = 6'h01;
      4'h1: div_last = 6'h03;
      4'h2: div_last = 6'h07;
      4'h3: div_last = 6'h0F;
      4'h4: div_last = 6'h1F;
      4'h5: div_last = 6'h3F;
      4'h8: div_last = 6'h05;
      4'h9: div_last = 6'h09;
      4'hA: div_last = 6'h0B;
      4'hB: div_last = 6'h17;
      4'hC: div_last = 6'h2F;
      default: div_last = 6'h01;
    endcase
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic       clock_output_enable;
  logic [1:0] sel;
  logic [3:0] prescale_divide_field;
  logic       prescale_enable_bit;
  logic       lock_enable_bit;
  logic       fast_stdby;
  logic       slow_stdby;
  logic [5:0] freq_trim;
  logic [3:0] temp_trim;
  logic       xen;
  logic       xsel;
  logic [1:0] crystal_startup_field;
  logic       x_stdby;
  logic [1:0] main_src;
  logic       switching;
  logic       loaded;
  logic       lock_fuse;
  csm_err_t   err_row;
  logic [2:0] key_win;

  // ****************************************************************
  // Key window and write qualification
  // ****************************************************************
  logic wr_ok;
  logic trim_ok;
  logic main_ok;

  assign wr_ok   = bus_i.wr && (key_win != 3'h0);
  assign main_ok = wr_ok && !lock_enable_bit;
  assign trim_ok = wr_ok && !lock_fuse
                && !(lock_enable_bit && main_src == `CSM_SRC_FAST);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      key_win <= 3'h0;
    else if (io_register_key_i)
      key_win <= `CSM_KEY_WINDOW;
    else if (bus_i.wr || key_win != 3'h0)
      key_win <= (bus_i.wr) ? 3'h0 : key_win - 3'h1;
  end

  // ****************************************************************
  // Main clock and lock registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clock_output_enable          <= 1'b0;
      sel             <= `CSM_SRC_FAST;
      prescale_divide_field            <= 4'h8;
      prescale_enable_bit             <= 1'b1;
      lock_enable_bit <= 1'b0;
    end
    else if (main_ok)
    begin
      if (bus_i.addr == `CSM_OFF_MCTRL)
      begin
        clock_output_enable <= bus_i.wdata[`CSM_BIT_CLOCK_OUTPUT_ENABLE];
        sel    <= bus_i.wdata[1:0];
      end
      if (bus_i.addr == `CSM_OFF_PRESC)
      begin
        prescale_divide_field <= bus_i.wdata[4:1];
        prescale_enable_bit  <= bus_i.wdata[`CSM_BIT_PEN];
      end
      if (bus_i.addr == `CSM_OFF_LOCK)
        lock_enable_bit <= bus_i.wdata[0];
    end
  end

  // ****************************************************************
  // Oscillator control registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fast_stdby            <= 1'b0;
      slow_stdby            <= 1'b0;
      xen                   <= 1'b0;
      xsel                  <= 1'b0;
      x_stdby               <= 1'b0;
      crystal_startup_field <= 2'h0;
    end
    else if (wr_ok)
    begin
      if (bus_i.addr == `CSM_OFF_FASTCTL)
        fast_stdby <= bus_i.wdata[`CSM_BIT_KEEP_RUNNING_BIT];
      if (bus_i.addr == `CSM_OFF_SLOWCTL)
        slow_stdby <= bus_i.wdata[`CSM_BIT_KEEP_RUNNING_BIT];
      if (bus_i.addr == `CSM_OFF_XTALCTL)
      begin
        xen                   <= bus_i.wdata[`CSM_BIT_XEN];
        x_stdby               <= bus_i.wdata[`CSM_BIT_KEEP_RUNNING_BIT];
        xsel                  <= bus_i.wdata[`CSM_BIT_XSEL];
        crystal_startup_field <= bus_i.wdata[5:4];
      end
    end
  end

  // ****************************************************************
  // Trims and fuse capture
  // ****************************************************************
  // Fuses are caught on the first edge after release, never under reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      loaded         <= 1'b0;
      lock_fuse      <= 1'b1;
      freq_trim      <= 6'h00;
      temp_trim      <= 4'h0;
      err_row        <= '0;
      center_20mhz_o <= 1'b0;
    end
    else if (!loaded)
    begin
      loaded         <= 1'b1;
      lock_fuse      <= trim_lock_fuse_i;
      freq_trim      <= fuse_freq_trim_i;
      temp_trim      <= fuse_temp_trim_i;
      err_row        <= factory_info_row_i;
      center_20mhz_o <= center_freq_fuse_i;
    end
    else if (trim_ok)
    begin
      if (bus_i.addr == `CSM_OFF_FTRIM)
        freq_trim <= bus_i.wdata[5:0];
      if (bus_i.addr == `CSM_OFF_TTRIM)
        temp_trim <= bus_i.wdata[3:0];
    end
  end

  // ****************************************************************
  // Start-up sequencing, one lane per source
  // ****************************************************************
  csm_req_t   run;
  csm_req_t   want;
  csm_start_t st [4];
  logic [16:0] cnt [4];
  logic [16:0] analog [4];
  logic [16:0] edges [4];
  csm_req_t   rdy;

  always_comb
  begin
    want.fast = req_i.fast || sel == `CSM_SRC_FAST
             || main_src == `CSM_SRC_FAST;
    want.slow = req_i.slow || sel == `CSM_SRC_SLOW
             || main_src == `CSM_SRC_SLOW;
    want.xtal = req_i.xtal || sel == `CSM_SRC_XTAL
             || main_src == `CSM_SRC_XTAL;
    want.ext  = req_i.ext || sel == `CSM_SRC_EXT
             || main_src == `CSM_SRC_EXT;
    run.fast  = want.fast || fast_stdby;
    run.slow  = want.slow || slow_stdby;
    run.xtal  = xen && (want.xtal || x_stdby);
    run.ext   = want.ext;
    analog[0] = 17'(FAST_CYC);
    analog[1] = 17'(SLOW_CYC);
    analog[2] = 17'h00000;
    analog[3] = 17'h00000;
    edges[0]  = `CSM_GATE_EDGES;
    edges[1]  = `CSM_GATE_EDGES;
    edges[3]  = `CSM_EXT_EDGES;
    if (xsel)
      edges[2] = `CSM_XEXT_EDGES;
    else
      unique case (crystal_startup_field)
        2'h0: edges[2] = `CSM_CSUT0_EDGES;
        2'h1: edges[2] = `CSM_CSUT1_EDGES;
        2'h2: edges[2] = `CSM_CSUT2_EDGES;
        2'h3: edges[2] = `CSM_CSUT3_EDGES;
      endcase
    rdy = {st[3] == CSM_READY, st[2] == CSM_READY,
           st[1] == CSM_READY, st[0] == CSM_READY};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        st[i]  <= CSM_OFF;
        cnt[i] <= 17'h00000;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!run[i])
        begin
          st[i]  <= CSM_OFF;
          cnt[i] <= 17'h00000;
        end
        else
          unique case (st[i])
            CSM_OFF:
            begin
              st[i]  <= (analog[i] != 17'h0) ? CSM_ANALOG : CSM_GATE;
              cnt[i] <= (analog[i] != 17'h0) ? analog[i] : edges[i];
            end
            CSM_ANALOG:
              if (cnt[i] == 17'h00001)
              begin
                st[i]  <= CSM_GATE;
                cnt[i] <= edges[i];
              end
              else
                cnt[i] <= cnt[i] - 17'h00001;
            CSM_GATE:
              if (edge_i[i])
              begin
                cnt[i] <= cnt[i] - 17'h00001;
                if (cnt[i] == 17'h00001)
                  st[i] <= CSM_READY;
              end
            CSM_READY:
              st[i] <= CSM_READY;
          endcase
      end
    end
  end

  // ****************************************************************
  // Source switching
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      main_src  <= `CSM_SRC_FAST;
      switching <= 1'b0;
    end
    else if (sel != main_src)
    begin
      switching <= !rdy[sel];
      if (rdy[sel])
        main_src <= sel;
    end
    else
      switching <= 1'b0;
  end

  // ****************************************************************
  // Prescaler and 1 kHz tick
  // ****************************************************************
  logic [5:0] div_cnt;
  logic [4:0] khz_cnt;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_cnt      <= 6'h00;
      per_clk_en_o <= 1'b0;
    end
    else if (!prescale_enable_bit)
    begin
      div_cnt      <= 6'h00;
      per_clk_en_o <= 1'b1;
    end
    else
    begin
      per_clk_en_o <= (div_cnt >= div_last(prescale_divide_field));
      div_cnt      <= (div_cnt >= div_last(prescale_divide_field)) ? 6'h00 : div_cnt + 6'h01;
    end
  end

  // Divides the 32 kHz edges by 32; only counts once the output is open
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      khz_cnt     <= 5'h00;
      tick_1khz_o <= 1'b0;
    end
    else
    begin
      tick_1khz_o <= rdy.slow && edge_i.slow && khz_cnt == `CSM_KHZ_DIV;
      if (rdy.slow && edge_i.slow)
        khz_cnt <= khz_cnt + 5'h01;
    end
  end

  // ****************************************************************
  // Registered outputs and read port
  // ****************************************************************
  logic [7:0] status;
  assign status = {rdy.ext && want.ext, rdy.xtal && want.xtal,
                   rdy.slow && want.slow, rdy.fast && want.fast,
                   3'h0, switching};

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_on_o                <= '0;
      osc_ready_o             <= '0;
      crystal_pin_override_o  <= 1'b0;
      crystal_ext_input_o     <= 1'b0;
      ext_pin_claim_o         <= 1'b0;
      freq_trim_field_o       <= 6'h00;
      temp_slope_trim_field_o <= 4'h0;
      main_source_o           <= `CSM_SRC_FAST;
      clock_output_enable_o   <= 1'b0;
    end
    else
    begin
      osc_on_o                <= run;
      osc_ready_o             <= rdy & want;
      crystal_pin_override_o  <= xen;
      crystal_ext_input_o     <= xsel;
      ext_pin_claim_o         <= run.ext;
      freq_trim_field_o       <= freq_trim;
      temp_slope_trim_field_o <= temp_trim;
      main_source_o           <= main_src;
      clock_output_enable_o   <= clock_output_enable;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (bus_i.rd)
      unique case (bus_i.addr)
        `CSM_OFF_MCTRL:   rdata_o <= {clock_output_enable, 5'h00, sel};
        `CSM_OFF_PRESC:   rdata_o <= {3'h0, prescale_divide_field, prescale_enable_bit};
        `CSM_OFF_LOCK:    rdata_o <= {7'h00, lock_enable_bit};
        `CSM_OFF_STATUS:  rdata_o <= status;
        `CSM_OFF_FASTCTL: rdata_o <= {6'h00, fast_stdby, 1'b0};
        `CSM_OFF_FTRIM:   rdata_o <= {2'h0, freq_trim};
        `CSM_OFF_TTRIM:   rdata_o <= {lock_fuse, 3'h0, temp_trim};
        `CSM_OFF_SLOWCTL: rdata_o <= {6'h00, slow_stdby, 1'b0};
        `CSM_OFF_XTALCTL: rdata_o <= {2'h0, crystal_startup_field, 1'b0,
                                      xsel, x_stdby, xen};
        8'h20:            rdata_o <= err_row.lo_lv;
        8'h21:            rdata_o <= err_row.lo_hv;
        8'h22:            rdata_o <= err_row.hi_lv;
        `CSM_OFF_ERR3:    rdata_o <= err_row.hi_hv;
        default:          rdata_o <= 8'h00;
      endcase
    else
      rdata_o <= 8'h00;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence key_gone_s;
    !io_register_key_i && key_win == 3'h0;
  endsequence

  no_key_write_a: assert property (
    key_gone_s ##0 bus_i.wr |=> $stable({sel, prescale_divide_field, prescale_enable_bit, xen}))
    else $error("unkeyed write changed a protected field");
  fuse_lock_a: assert property (
    loaded && lock_fuse |=> $stable(freq_trim) && $stable(temp_trim))
    else $error("trim changed under fuse lock");
  main_lock_a: assert property (
    loaded && lock_enable_bit && main_src == `CSM_SRC_FAST
    |=> $stable(freq_trim))
    else $error("trim changed while locked as main source");
  lock_hold_a: assert property (
    lock_enable_bit |=> lock_enable_bit && $stable({sel, prescale_divide_field, prescale_enable_bit}))
    else $error("lock released or main control changed");
  undivided_a: assert property (
    !prescale_enable_bit ##1 !prescale_enable_bit |-> per_clk_en_o)
    else $error("peripheral enable gap with prescaler off");
  fast_gate_a: assert property (
    $rose(rdy.fast) |-> $past(st[0] == CSM_GATE) && $past(edge_i.fast))
    else $error("fast output opened without gate edges");
  xtal_off_a: assert property (
    !xen |=> st[2] == CSM_OFF)
    else $error("crystal runs while disabled");
  pin_follow_a: assert property (
    xen |=> crystal_pin_override_o)
    else $error("crystal pins not overridden when enabled");
  ext_mode_a: assert property (
    xsel && run.xtal && st[2] == CSM_OFF
    |=> st[2] == CSM_GATE && cnt[2] == 17'h00002)
    else $error("external-clock crystal mode not loaded with two edges");
  reserved_a: assert property (
    bus_i.rd && bus_i.addr > `CSM_OFF_ERR3 |=> rdata_o == 8'h00)
    else $error("reserved offset read nonzero");
  switch_a: assert property (
    sel != main_src && rdy[sel] |=> main_src == $past(sel) && !switching)
    else $error("main source did not switch to a ready source");

endmodule
`default_nettype wire

// ---- testbench/csm_top_tb.sv ----
// Self-checking bench for the clock source manager register port.
// Assumes csm_pkg is compiled first; oscillator edges come as pulses.
`timescale 1ns/1ps
`default_nettype none
module csm_top_tb;
  import csm_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  csm_bus_t         bus_i = '0;
  logic             io_register_key_i = 1'b0;
  csm_req_t         req_i = 4'b0001;
  csm_req_t         edge_i = '0;
  logic             center_freq_fuse_i = 1'b1;
  logic             trim_lock_fuse_i = 1'b0;
  logic [5:0]       fuse_freq_trim_i = 6'h1B;
  logic [3:0]       fuse_temp_trim_i = 4'h9;
  // Error bytes of both signs; a 0x4A divisor stays legal under each
  csm_err_t         factory_info_row_i = 32'hC311857F;
  logic [7:0]       rdata_o;
  csm_req_t         osc_on_o;
  csm_req_t         osc_ready_o;
  logic             crystal_pin_override_o;
  logic             crystal_ext_input_o;
  logic             ext_pin_claim_o;
  logic             center_20mhz_o;
  logic [5:0]       freq_trim_field_o;
  logic [3:0]       temp_slope_trim_field_o;
  logic [1:0]       main_source_o;
  logic             per_clk_en_o;
  logic             clock_output_enable_o;
  logic             tick_1khz_o;
  int               bad_count = 0;
  int               n_checks = 0;
  int               ticks = 0;
  int               t0;
  int               c;
  logic [7:0]       offs [7] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h18,
                                 8'h1C, 8'h05};
  logic [7:0]       rsts [7] = '{8'h00, 8'h11, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h00};

  // Short analog start-up keeps the run brief
  csm_top #(.FAST_START_NS(100), .SLOW_START_NS(100)) dut (
    .clk_i, .rst_i, .bus_i, .rdata_o, .io_register_key_i, .req_i, .edge_i,
    .center_freq_fuse_i, .trim_lock_fuse_i, .fuse_freq_trim_i,
    .fuse_temp_trim_i, .factory_info_row_i, .osc_on_o, .osc_ready_o,
    .crystal_pin_override_o, .crystal_ext_input_o, .ext_pin_claim_o,
    .center_20mhz_o, .freq_trim_field_o, .temp_slope_trim_field_o,
    .main_source_o, .per_clk_en_o, .clock_output_enable_o, .tick_1khz_o);

  always #20 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    if (tick_1khz_o === 1'b1)
      ticks <= ticks + 1;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= {a, d, 2'b10};
    @(posedge clk_i);
    bus_i <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus_i <= {a, 8'h00, 2'b01};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
    chk($sformatf("register %h", a), exp, rdata_o);
  endtask

  task automatic key();
    @(posedge clk_i);
    io_register_key_i <= 1'b1;
    @(posedge clk_i);
    io_register_key_i <= 1'b0;
  endtask

  // Edge pulses are spaced so each one is seen as a separate edge
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      edge_i <= m;
      @(posedge clk_i);
      edge_i <= '0;
    end
    tick(2);
  endtask

  task automatic cnt(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      if (per_clk_en_o === 1'b1)
        k++;
    end
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(3);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    do_reset();
    chk("center", 8'h01, {7'h00, center_20mhz_o});
    chk("freq trim", 8'h1B, {2'h0, freq_trim_field_o});
    chk("temp trim", 8'h09, {4'h0, temp_slope_trim_field_o});
    for (int i = 0; i < 7; i++)
      rd(offs[i], rsts[i]);
    for (int i = 0; i < 4; i++)
      rd(8'h20 + 8'(i), factory_info_row_i[8*i +: 8]);
    key();
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    done("reset");
    cnt(12, c);
    chk("per enable div6", 8'h02, c[7:0]);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h11);
    key();
    tick(5);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h11);
    key();
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
    cnt(12, c);
    chk("per enable undivided", 8'h0C, c[7:0]);
    done("prescale");
    key();
    wr(8'h01, 8'h0B);
    key();
    wr(8'h11, 8'h2A);
    rd(8'h11, 8'h2A);
    chk("freq trim", 8'h2A, {2'h0, freq_trim_field_o});
    key();
    wr(8'h12, 8'hF5);
    rd(8'h12, 8'h05);
    chk("temp trim", 8'h05, {4'h0, temp_slope_trim_field_o});
    key();
    wr(8'h01, 8'h00);
    done("trim");
    pulse(4'b0001, 3);
    chk("fast ready early", 8'h00, {7'h00, osc_ready_o.fast});
    pulse(4'b0001, 3);
    chk("fast ready", 8'h01, {7'h00, osc_ready_o.fast});
    @(posedge clk_i) req_i.slow <= 1'b1;
    tick(10);
    pulse(4'b0010, 3);
    chk("slow ready early", 8'h00, {7'h00, osc_ready_o.slow});
    pulse(4'b0010, 1);
    chk("slow ready", 8'h01, {7'h00, osc_ready_o.slow});
    chk("slow on", 8'h01, {7'h00, osc_on_o.slow});
    rd(8'h03, 8'h30);
    t0 = ticks;
    pulse(4'b0010, 64);
    chk("khz ticks", 8'h02, 8'(ticks - t0));
    @(posedge clk_i) req_i.ext <= 1'b1;
    tick(2);
    chk("ext claim", 8'h01, {7'h00, ext_pin_claim_o});
    pulse(4'b1000, 1);
    chk("ext ready early", 8'h00, {7'h00, osc_ready_o.ext});
    pulse(4'b1000, 1);
    chk("ext ready", 8'h01, {7'h00, osc_ready_o.ext});
    @(posedge clk_i) req_i.xtal <= 1'b1;
    tick(3);
    chk("crystal off", 8'h00, {7'h00, osc_on_o.xtal});
    key();
    wr(8'h1C, 8'h05);
    tick(2);
    chk("pin override", 8'h01, {7'h00, crystal_pin_override_o});
    chk("ext input", 8'h01, {7'h00, crystal_ext_input_o});
    pulse(4'b0100, 2);
    chk("crystal ready", 8'h01, {7'h00, osc_ready_o.xtal});
    rd(8'h03, 8'hF0);
    done("oscillators");
    key();
    wr(8'h00, 8'h81);
    tick(4);
    chk("main source", 8'h01, {6'h00, main_source_o});
    chk("clock out", 8'h01, {7'h00, clock_output_enable_o});
    key();
    wr(8'h00, 8'h00);
    tick(4);
    chk("main source", 8'h00, {6'h00, main_source_o});
    done("select");
    key();
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h01);
    key();
    wr(8'h11, 8'h15);
    rd(8'h11, 8'h2A);
    key();
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    done("lock");
    @(posedge clk_i);
    trim_lock_fuse_i <= 1'b1;
    center_freq_fuse_i <= 1'b0;
    fuse_freq_trim_i <= 6'h24;
    do_reset();
    chk("center", 8'h00, {7'h00, center_20mhz_o});
    key();
    wr(8'h11, 8'h3F);
    rd(8'h11, 8'h24);
    rd(8'h12, 8'h89);
    done("fuse lock");
    print_verdict();
  end

  // Whole run is about 350 cycles; this leaves a wide margin
  initial
  begin
    #400000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
